// file: core/rldbg_map.svh
// Notes on behaviour
// - All transceiver status flags are asynchronous; they are synchronised before use.
// - The receive data-lock flag is always present, debug option or not.
// - With the debug option on, extra transceiver status outputs are exposed.
// - Reference-lock flag is high while the receive CDR tracks its reference clock.
// - Code-violation vector bit n flags an 8B/10B code error in byte n.
// - Disparity-error vector bit n flags an 8B/10B disparity error in byte n.
// - Sync-header error flag is raised on any invalid 64B/66B sync header.
// - Forward-loop 01 with serial loop built in selects the serial media loop.
// - Forward-loop 10 is parallel loop with stitching, 11 is parallel without.
// - Any parallel forward loop bypasses the transceiver entirely.
// - A nonzero reverse-loop field with reverse loop built in activates it.
// - Reverse-loop value picks looped frame parts; the rest come from local core.
// - By default a slave withholds K28.5 until its receiver has locked.
// - Without the override only a master works in external loopback.
// - Transmit-force set to 1 lets a slave send K28.5 before receive lock.
`ifndef RLDBG_MAP_SVH
`define RLDBG_MAP_SVH

`define RLDBG_ADDR_LOOPBACK    8'h00
`define RLDBG_ADDR_L1CFG       8'h04
`define RLDBG_ADDR_STATUS      8'h08
`define RLDBG_ADDR_IRQ_STATUS  8'h0C
`define RLDBG_ADDR_IRQ_MASK    8'h10
`define RLDBG_ADDR_LINK        8'h14

`define RLDBG_FWD_LSB          0
`define RLDBG_REV_LSB          8
`define RLDBG_REV_W            4
`define RLDBG_FORCE_BIT        0
`define RLDBG_ROLE_BIT         1

`define RLDBG_FWD_NONE         2'h0
`define RLDBG_FWD_SERIAL       2'h1
`define RLDBG_FWD_PAR_STITCH   2'h2
`define RLDBG_FWD_PAR_RAW      2'h3

`define RLDBG_IRQ_W            6
`define RLDBG_RESET_WORD       32'h0000_0000

`define RLDBG_K285_WORD        32'h0000_00BC
`define RLDBG_K285_CTRL        4'h1

`define RLDBG_CLK_PERIOD_NS    25
`define RLDBG_LOCK_HOLD_NS     400
`define RLDBG_LOCK_HOLD_CYC    ((`RLDBG_LOCK_HOLD_NS + `RLDBG_CLK_PERIOD_NS - 1) / `RLDBG_CLK_PERIOD_NS)

`endif

// file: core/rldbg_pkg.sv
package rldbg_pkg;

	typedef enum logic [1:0] {
		RLDBG_PATH_NORMAL  = 2'b00,
		RLDBG_PATH_SERIAL  = 2'b01,
		RLDBG_PATH_STITCH  = 2'b10,
		RLDBG_PATH_RAW     = 2'b11
	} rldbg_path_t;

	typedef struct packed {
		logic       data_locked;
		logic       ref_locked;
		logic [3:0] code_err;
		logic [3:0] disp_err;
		logic       sh_err;
	} rldbg_xcvr_stat_t;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0]  ctrl;
	} rldbg_word_t;

endpackage : rldbg_pkg

// file: core/rldbg_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rldbg_map.svh"

module rldbg_top
	import rldbg_pkg::*;
#(
	parameter bit SERIAL_LOOP_EN = 1'b1,
	parameter bit PAR_FWD_EN     = 1'b1,
	parameter bit PAR_REV_EN     = 1'b1,
	parameter bit DEBUG_EN       = 1'b1
) (
	// Clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RESET_I,
	// AXI4-Lite slave
	input  wire logic [7:0]        AWADDR_I,
	input  wire logic              AWVALID_I,
	output logic                   AWREADY_O,
	input  wire logic [31:0]       WDATA_I,
	input  wire logic [3:0]        WSTRB_I,
	input  wire logic              WVALID_I,
	output logic                   WREADY_O,
	output logic [1:0]             BRESP_O,
	output logic                   BVALID_O,
	input  wire logic              BREADY_I,
	input  wire logic [7:0]        ARADDR_I,
	input  wire logic              ARVALID_I,
	output logic                   ARREADY_O,
	output logic [31:0]            RDATA_O,
	output logic [1:0]             RRESP_O,
	output logic                   RVALID_O,
	input  wire logic              RREADY_I,
	// Asynchronous transceiver status
	input  wire rldbg_xcvr_stat_t  XCVR_STAT_I,
	input  wire logic              LINK_CLK_I,
	// Data paths
	input  wire rldbg_word_t       CORE_TX_I,
	input  wire rldbg_word_t       XCVR_RX_I,
	input  wire logic              RX_K285_LOCK_I,
	output rldbg_word_t            XCVR_TX_O,
	output rldbg_word_t            CORE_RX_O,
	// Transceiver loop controls
	output logic                   SERIAL_LOOP_O,
	output logic                   XCVR_BYPASS_O,
	output logic                   STITCH_BYPASS_O,
	output logic                   TX_K285_EN_O,
	// Status and interrupt
	output logic                   RX_CDR_DATA_LOCKED_O,
	output logic                   RX_CDR_REF_LOCKED_O,
	output logic [3:0]             RX_CODE_ERR_O,
	output logic [3:0]             RX_DISP_ERR_O,
	output logic                   RX_SYNC_HEADER_ERROR_O,
	output logic                   IRQ_O
);

	localparam int STAT_W = $bits(rldbg_xcvr_stat_t);

	// Two-stage synchroniser for async status, three-stage for link clock
	logic [STAT_W-1:0] stat_m_r, stat_s_r;
	logic [1:0]        lclk_m_r;
	logic              lclk_s_r, lclk_d_r;
	rldbg_xcvr_stat_t  stat;

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			stat_m_r <= '0;
			stat_s_r <= '0;
			lclk_m_r <= 2'h0;
			lclk_s_r <= 1'b0;
			lclk_d_r <= 1'b0;
		end else begin
			stat_m_r <= XCVR_STAT_I;
			stat_s_r <= stat_m_r;
			lclk_m_r <= {lclk_m_r[0], LINK_CLK_I};
			lclk_s_r <= lclk_m_r[1];
			lclk_d_r <= lclk_s_r;
		end
	end
	assign stat = rldbg_xcvr_stat_t'(stat_s_r);
	wire lclk_rise = lclk_s_r & ~lclk_d_r;

	// Registers
	logic [1:0]               fwd_r;
	logic [`RLDBG_REV_W-1:0]  rev_r;
	logic                     force_r;
	logic                     slave_r;
	logic [`RLDBG_IRQ_W-1:0]  irq_stat_r, irq_mask_r;
	logic [15:0]              link_cnt_r;

	// Write channel
	logic        aw_hold_r, w_hold_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	wire         aw_take = AWVALID_I & AWREADY_O;
	wire         w_take  = WVALID_I & WREADY_O;
	wire         aw_have = aw_hold_r | aw_take;
	wire         w_have  = w_hold_r | w_take;
	wire  [7:0]  wa      = aw_hold_r ? aw_addr_r : AWADDR_I;
	wire  [31:0] wd      = w_hold_r ? w_data_r : WDATA_I;
	wire  [3:0]  ws      = w_hold_r ? w_strb_r : WSTRB_I;
	wire         do_wr   = aw_have & w_have & ~BVALID_O;

	function automatic logic known(input logic [7:0] a);
		case (a)
			`RLDBG_ADDR_LOOPBACK, `RLDBG_ADDR_L1CFG, `RLDBG_ADDR_STATUS,
			`RLDBG_ADDR_IRQ_STATUS, `RLDBG_ADDR_IRQ_MASK, `RLDBG_ADDR_LINK: known = 1'b1;
			default: known = 1'b0;
		endcase
	endfunction : known

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			AWREADY_O <= 1'b0;
			WREADY_O  <= 1'b0;
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			BVALID_O  <= 1'b0;
			BRESP_O   <= 2'h0;
		end else begin
			AWREADY_O <= ~aw_have & ~BVALID_O & ~do_wr;
			WREADY_O  <= ~w_have & ~BVALID_O & ~do_wr;
			if (aw_take) begin
				aw_addr_r <= AWADDR_I;
			end
			if (w_take) begin
				w_data_r <= WDATA_I;
				w_strb_r <= WSTRB_I;
			end
			aw_hold_r <= aw_have & ~do_wr;
			w_hold_r  <= w_have & ~do_wr;
			if (do_wr) begin
				BVALID_O <= 1'b1;
				BRESP_O  <= known(wa) ? 2'h0 : 2'h2;
			end else if (BREADY_I) begin
				BVALID_O <= 1'b0;
			end
		end
	end

	// Control registers, byte lane 0 and 1 only
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			fwd_r      <= 2'h0;
			rev_r      <= '0;
			force_r    <= 1'b0;
			slave_r    <= 1'b0;
			irq_mask_r <= '0;
		end else if (do_wr) begin
			case (wa)
				`RLDBG_ADDR_LOOPBACK: begin
					if (ws[0]) fwd_r <= wd[`RLDBG_FWD_LSB +: 2];
					if (ws[1]) rev_r <= wd[`RLDBG_REV_LSB +: `RLDBG_REV_W];
				end
				`RLDBG_ADDR_L1CFG: begin
					if (ws[0]) begin
						force_r <= wd[`RLDBG_FORCE_BIT];
						slave_r <= wd[`RLDBG_ROLE_BIT];
					end
				end
				`RLDBG_ADDR_IRQ_MASK: begin
					if (ws[0]) irq_mask_r <= wd[`RLDBG_IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Sticky events: lock loss, ref lock loss, code, disparity, sync header, link clock
	logic [`RLDBG_IRQ_W-1:0] ev;
	logic                    dl_d_r, rl_d_r;
	assign ev = {lclk_rise, stat.sh_err, |stat.disp_err, |stat.code_err,
		rl_d_r & ~stat.ref_locked, dl_d_r & ~stat.data_locked};

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			dl_d_r     <= 1'b0;
			rl_d_r     <= 1'b0;
			irq_stat_r <= '0;
			link_cnt_r <= 16'h0000;
			IRQ_O      <= 1'b0;
		end else begin
			dl_d_r <= stat.data_locked;
			rl_d_r <= stat.ref_locked;
			if (lclk_rise) link_cnt_r <= link_cnt_r + 16'h0001;
			// Set beats clear
			if (do_wr && wa == `RLDBG_ADDR_IRQ_STATUS && ws[0])
				irq_stat_r <= (irq_stat_r & ~wd[`RLDBG_IRQ_W-1:0]) | ev;
			else
				irq_stat_r <= irq_stat_r | ev;
			IRQ_O <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Read channel
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0000_0000;
		case (ARADDR_I)
			`RLDBG_ADDR_LOOPBACK: begin
				rd[`RLDBG_FWD_LSB +: 2] = fwd_r;
				rd[`RLDBG_REV_LSB +: `RLDBG_REV_W] = rev_r;
			end
			`RLDBG_ADDR_L1CFG: begin
				rd[`RLDBG_FORCE_BIT] = force_r;
				rd[`RLDBG_ROLE_BIT]  = slave_r;
			end
			`RLDBG_ADDR_STATUS:     rd[STAT_W-1:0] = stat;
			`RLDBG_ADDR_IRQ_STATUS: rd[`RLDBG_IRQ_W-1:0] = irq_stat_r;
			`RLDBG_ADDR_IRQ_MASK:   rd[`RLDBG_IRQ_W-1:0] = irq_mask_r;
			`RLDBG_ADDR_LINK:       rd[15:0] = link_cnt_r;
			default:                rd = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ARREADY_O <= 1'b0;
			RVALID_O  <= 1'b0;
			RDATA_O   <= 32'h0000_0000;
			RRESP_O   <= 2'h0;
		end else begin
			ARREADY_O <= ~RVALID_O & ~(ARVALID_I & ARREADY_O);
			if (ARVALID_I && ARREADY_O) begin
				RVALID_O <= 1'b1;
				RDATA_O  <= rd;
				RRESP_O  <= known(ARADDR_I) ? 2'h0 : 2'h2;
			end else if (RREADY_I) begin
				RVALID_O <= 1'b0;
			end
		end
	end

	// Loop path selection
	rldbg_path_t path;
	logic        rev_on;
	always_comb begin
		case (fwd_r)
			`RLDBG_FWD_SERIAL:    path = SERIAL_LOOP_EN ? RLDBG_PATH_SERIAL : RLDBG_PATH_NORMAL;
			`RLDBG_FWD_PAR_STITCH: path = PAR_FWD_EN ? RLDBG_PATH_STITCH : RLDBG_PATH_NORMAL;
			`RLDBG_FWD_PAR_RAW:   path = PAR_FWD_EN ? RLDBG_PATH_RAW : RLDBG_PATH_NORMAL;
			default:              path = RLDBG_PATH_NORMAL;
		endcase
	end
	assign rev_on = PAR_REV_EN && (rev_r != '0);

	// K28.5 gating: master always, slave after lock or when forced
	wire k_ok = ~slave_r | RX_K285_LOCK_I | force_r;
	rldbg_word_t tx_word, rx_word;

	always_comb begin
		tx_word = CORE_TX_I;
		if (rev_on) begin
			for (int b = 0; b < 4; b++) begin
				// Selected byte lanes come from received data
				if (rev_r[b]) begin
					tx_word.data[8*b +: 8] = XCVR_RX_I.data[8*b +: 8];
					tx_word.ctrl[b]        = XCVR_RX_I.ctrl[b];
				end
			end
		end
		if (!k_ok && CORE_TX_I.ctrl != 4'h0) begin
			tx_word.data = 32'h0000_0000;
			tx_word.ctrl = 4'h0;
		end
		rx_word = XCVR_RX_I;
		if (path == RLDBG_PATH_STITCH || path == RLDBG_PATH_RAW)
			rx_word = tx_word;
	end

	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			XCVR_TX_O       <= '0;
			CORE_RX_O       <= '0;
			SERIAL_LOOP_O   <= 1'b0;
			XCVR_BYPASS_O   <= 1'b0;
			STITCH_BYPASS_O <= 1'b0;
			TX_K285_EN_O    <= 1'b0;
		end else begin
			XCVR_TX_O       <= tx_word;
			CORE_RX_O       <= rx_word;
			SERIAL_LOOP_O   <= (path == RLDBG_PATH_SERIAL);
			XCVR_BYPASS_O   <= (path == RLDBG_PATH_STITCH) || (path == RLDBG_PATH_RAW);
			STITCH_BYPASS_O <= (path == RLDBG_PATH_RAW);
			TX_K285_EN_O    <= k_ok;
		end
	end

	// Status outputs
	always_ff @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			RX_CDR_DATA_LOCKED_O   <= 1'b0;
			RX_CDR_REF_LOCKED_O    <= 1'b0;
			RX_CODE_ERR_O          <= 4'h0;
			RX_DISP_ERR_O          <= 4'h0;
			RX_SYNC_HEADER_ERROR_O <= 1'b0;
		end else begin
			RX_CDR_DATA_LOCKED_O   <= stat.data_locked;
			RX_CDR_REF_LOCKED_O    <= DEBUG_EN & stat.ref_locked;
			RX_CODE_ERR_O          <= DEBUG_EN ? stat.code_err : 4'h0;
			RX_DISP_ERR_O          <= DEBUG_EN ? stat.disp_err : 4'h0;
			RX_SYNC_HEADER_ERROR_O <= DEBUG_EN & stat.sh_err;
		end
	end

	// Checks
	AST_SERIAL_PATH: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(fwd_r == 2'h1) |=> SERIAL_LOOP_O == SERIAL_LOOP_EN)
		else $error("serial loop not selected");
	AST_BYPASS: assert property (@(posedge CLK_I) disable iff (RESET_I)
		fwd_r[1] |=> XCVR_BYPASS_O == PAR_FWD_EN && !SERIAL_LOOP_O)
		else $error("parallel loop does not bypass");
	AST_STITCH: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(fwd_r == 2'h2) |=> !STITCH_BYPASS_O)
		else $error("stitch path wrong");
	AST_NORMAL: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(!RESET_I && fwd_r == 2'h0 && rev_r == '0) |=> !SERIAL_LOOP_O && !XCVR_BYPASS_O
			&& XCVR_TX_O == $past(tx_word))
		else $error("loop active in normal mode");
	AST_K_HOLD: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(slave_r && !force_r && !RX_K285_LOCK_I) |=> !TX_K285_EN_O)
		else $error("slave sent K28.5 before lock");
	AST_FORCE: assert property (@(posedge CLK_I) disable iff (RESET_I)
		force_r |=> TX_K285_EN_O)
		else $error("forced K28.5 not sent");
	AST_MASTER: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(!RESET_I && !slave_r) |=> TX_K285_EN_O)
		else $error("master blocked");
	AST_LOCK: assert property (@(posedge CLK_I) disable iff (RESET_I)
		XCVR_STAT_I.data_locked [*4] |-> ##1 RX_CDR_DATA_LOCKED_O)
		else $error("data lock not reported");
	AST_REV: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(rev_on && rev_r[0] && k_ok) |=> XCVR_TX_O.data[7:0] == $past(XCVR_RX_I.data[7:0]))
		else $error("reverse byte not looped");

	// Data path and status checks
	AST_PAR_RX: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(PAR_FWD_EN && fwd_r[1]) |=> CORE_RX_O == XCVR_TX_O)
		else $error("parallel loop data not returned");
	AST_SERIAL_DATA: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(fwd_r == 2'h1) |=> !XCVR_BYPASS_O && CORE_RX_O == $past(XCVR_RX_I))
		else $error("serial loop data path wrong");
	AST_NORMAL_RX: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(!RESET_I && fwd_r == 2'h0 && rev_r == '0) |=> CORE_RX_O == $past(XCVR_RX_I))
		else $error("receive path altered in normal mode");
	AST_K_BLANK: assert property (@(posedge CLK_I) disable iff (RESET_I)
		(slave_r && !force_r && !RX_K285_LOCK_I && CORE_TX_I.ctrl != 4'h0) |=> XCVR_TX_O == '0)
		else $error("control word sent before lock");
	AST_REF_LOCK: assert property (@(posedge CLK_I) disable iff (RESET_I)
		stat.ref_locked |=> RX_CDR_REF_LOCKED_O == DEBUG_EN)
		else $error("reference lock not reported");
	AST_SH_ERR: assert property (@(posedge CLK_I) disable iff (RESET_I)
		stat.sh_err |=> RX_SYNC_HEADER_ERROR_O == DEBUG_EN)
		else $error("sync header error not reported");

	// Per-lane error flags and reverse fill
	for (genvar g = 0; g < 4; g++) begin : g_lane_chk
		AST_CODE_LANE: assert property (@(posedge CLK_I) disable iff (RESET_I)
			stat.code_err[g] |=> RX_CODE_ERR_O[g] == DEBUG_EN)
			else $error("code violation lane lost");
		AST_DISP_LANE: assert property (@(posedge CLK_I) disable iff (RESET_I)
			stat.disp_err[g] |=> RX_DISP_ERR_O[g] == DEBUG_EN)
			else $error("disparity error lane lost");
		AST_REV_FILL: assert property (@(posedge CLK_I) disable iff (RESET_I)
			(!RESET_I && (k_ok || CORE_TX_I.ctrl == 4'h0) && !(rev_on && rev_r[g]))
			|=> XCVR_TX_O.data[8*g +: 8] == $past(CORE_TX_I.data[8*g +: 8]))
			else $error("unselected lane not from core");
	end

endmodule : rldbg_top
`default_nettype wire

// file: testbench/rldbg_peer.sv
`timescale 1ns/1ps
`default_nettype none

module rldbg_peer
	import rldbg_pkg::*;
#(
	parameter logic [31:0] PEER_WORD = 32'hC3A5_5A3C
) (
	// Clock and test controls
	input  wire logic             clk_i,
	input  wire logic             loop_i,
	input  wire rldbg_xcvr_stat_t stat_i,
	// Link side
	input  wire rldbg_word_t      tx_i,
	output rldbg_word_t           rx_o,
	output rldbg_xcvr_stat_t      stat_o,
	output logic                  k285_lock_o
);
	// Own traffic differs from the core's so loop paths can be told apart
	always_ff @(posedge clk_i) begin
		rx_o        <= loop_i ? tx_i : {PEER_WORD, 4'h0};
		k285_lock_o <= loop_i && tx_i.ctrl[0] && (tx_i.data[7:0] == 8'hBC);
	end
	// Flags move off the core clock edges
	always @(posedge clk_i) stat_o <= #3 stat_i;
endmodule : rldbg_peer

`default_nettype wire

// file: testbench/test_radio_link_loopback_debug.sv
`timescale 1ns/1ps
`default_nettype none
`include "rldbg_map.svh"

module test_radio_link_loopback_debug
	import rldbg_pkg::*;
;
	localparam logic [31:0] PEER_W = 32'hC3A5_5A3C;
	localparam rldbg_word_t CORE_W = {32'h1234_5678, 4'h0};
	localparam rldbg_word_t K_W    = {`RLDBG_K285_WORD, `RLDBG_K285_CTRL};
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             link_clk = 1'b0;
	logic             peer_loop = 1'b0;
	logic [7:0]       aw_addr = 8'h00;
	logic [7:0]       ar_addr = 8'h00;
	logic [31:0]      w_data = 32'h0;
	logic             aw_valid = 1'b0;
	logic             w_valid = 1'b0;
	logic             b_ready = 1'b0;
	logic             ar_valid = 1'b0;
	logic             r_ready = 1'b0;
	rldbg_xcvr_stat_t stat_drv = '0;
	rldbg_word_t      core_tx = CORE_W;
	logic             awready, wready, bvalid, arready, rvalid;
	logic [1:0]       bresp, rresp;
	logic [31:0]      rdata, d;
	logic [1:0]       r;
	rldbg_xcvr_stat_t peer_stat;
	rldbg_word_t      peer_rx, xcvr_tx, core_rx;
	logic             peer_lock, serial_loop, xcvr_bypass, stitch_bypass, k285_en;
	logic             dl, rl, sh_err, irq;
	logic [3:0]       code_err, disp_err;
	int               bad_count = 0;
	int               cmp_count = 0;

	always #12.5 clk = ~clk;
	initial begin
		#7;
		forever #100 link_clk = ~link_clk; // External transmit clock source
	end

	rldbg_peer #(.PEER_WORD(PEER_W)) u_peer (.clk_i(clk), .loop_i(peer_loop), .stat_i(stat_drv),
		.tx_i(xcvr_tx), .rx_o(peer_rx), .stat_o(peer_stat), .k285_lock_o(peer_lock));

	rldbg_top u_dut (.CLK_I(clk), .RESET_I(rst), .AWADDR_I(aw_addr), .AWVALID_I(aw_valid),
		.AWREADY_O(awready), .WDATA_I(w_data), .WSTRB_I(4'hF), .WVALID_I(w_valid),
		.WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(b_ready),
		.ARADDR_I(ar_addr), .ARVALID_I(ar_valid), .ARREADY_O(arready), .RDATA_O(rdata),
		.RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(r_ready), .XCVR_STAT_I(peer_stat),
		.LINK_CLK_I(link_clk), .CORE_TX_I(core_tx), .XCVR_RX_I(peer_rx),
		.RX_K285_LOCK_I(peer_lock), .XCVR_TX_O(xcvr_tx), .CORE_RX_O(core_rx),
		.SERIAL_LOOP_O(serial_loop), .XCVR_BYPASS_O(xcvr_bypass),
		.STITCH_BYPASS_O(stitch_bypass), .TX_K285_EN_O(k285_en),
		.RX_CDR_DATA_LOCKED_O(dl), .RX_CDR_REF_LOCKED_O(rl), .RX_CODE_ERR_O(code_err),
		.RX_DISP_ERR_O(disp_err), .RX_SYNC_HEADER_ERROR_O(sh_err), .IRQ_O(irq));

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat);
		@(posedge clk);
		aw_addr  <= a;
		w_data   <= dat;
		aw_valid <= 1'b1;
		w_valid  <= 1'b1;
		b_ready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) aw_valid <= 1'b0;
			if (wready === 1'b1) w_valid <= 1'b0;
		end while (bvalid !== 1'b1);
		b_ready <= 1'b0;
		// Write channels refused while the response pends
		check(36'({awready, wready}), 36'h0);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
		@(posedge clk);
		ar_addr  <= a;
		ar_valid <= 1'b1;
		r_ready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) ar_valid <= 1'b0;
		end while (rvalid !== 1'b1);
		dat = rdata;
		rs = rresp;
		r_ready <= 1'b0;
		// Read address refused while the data pends
		check(36'(arready), 36'h0);
	endtask : axi_rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  s;
		axi_rd(a, v, s);
		check(36'(s), 36'h0);
		check(36'(v & m), 36'(e));
	endtask : rd_chk

	function automatic logic [31:0] lane_mask(input logic [3:0] m);
		return {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
	endfunction : lane_mask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	initial begin
		#(25 * 20000);
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd_chk(`RLDBG_ADDR_LOOPBACK, 32'hFFFF_FFFF, `RLDBG_RESET_WORD);
		rd_chk(`RLDBG_ADDR_L1CFG, 32'hFFFF_FFFF, `RLDBG_RESET_WORD);
		axi_rd(8'h40, d, r);
		check(36'(r), 36'h2);
		axi_wr(8'h40, 32'hFFFF_FFFF);
		check(36'(bresp), 36'h2);
		check(xcvr_tx, CORE_W);
		check(core_rx, {PEER_W, 4'h0});
		check(36'({serial_loop, xcvr_bypass, stitch_bypass}), 36'h0);
		for (int f = 1; f < 4; f++) begin
			axi_wr(`RLDBG_ADDR_LOOPBACK, 32'(f));
			check(36'(bresp), 36'h0);
			repeat (3) @(posedge clk);
			check(36'({serial_loop, xcvr_bypass, stitch_bypass}), 36'({f == 1, f > 1, f == 3}));
			check(core_rx, (f > 1) ? CORE_W : {PEER_W, 4'h0});
		end
		for (int m = 1; m < 16; m++) begin
			axi_wr(`RLDBG_ADDR_LOOPBACK, 32'(m) << `RLDBG_REV_LSB);
			repeat (3) @(posedge clk);
			check(36'(xcvr_tx.data), 36'((PEER_W & lane_mask(4'(m))) | (CORE_W.data & ~lane_mask(4'(m)))));
		end
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd_chk(`RLDBG_ADDR_LOOPBACK, 32'hFFFF_FFFF, `RLDBG_RESET_WORD);
		core_tx   <= K_W;
		peer_loop <= 1'b1;
		repeat (6) @(posedge clk);
		check(36'(k285_en), 36'h1);
		check(xcvr_tx, K_W);
		peer_loop <= 1'b0;
		axi_wr(`RLDBG_ADDR_L1CFG, 32'h2);
		repeat (4) @(posedge clk);
		peer_loop <= 1'b1;
		repeat (8) @(posedge clk);
		check(36'(k285_en), 36'h0);
		check(xcvr_tx, 36'h0);
		check(36'(peer_lock), 36'h0);
		axi_wr(`RLDBG_ADDR_L1CFG, 32'h3);
		repeat (8) @(posedge clk);
		check(36'(k285_en), 36'h1);
		check(xcvr_tx, K_W);
		check(36'(peer_lock), 36'h1);
		rd_chk(`RLDBG_ADDR_L1CFG, 32'hFFFF_FFFF, 32'h3);
		peer_loop <= 1'b0;
		for (int n = 0; n < 4; n++) begin
			stat_drv <= {1'b1, 1'b1, 4'(1 << n), 4'(8 >> n), 1'(n == 3)};
			repeat (6) @(posedge clk);
			check(36'({dl, rl, code_err, disp_err, sh_err}), 36'(stat_drv));
			rd_chk(`RLDBG_ADDR_STATUS, 32'h7FF, 32'(stat_drv));
		end
		rd_chk(`RLDBG_ADDR_IRQ_STATUS, 32'h1C, 32'h1C);
		check(36'(irq), 36'h0);
		axi_wr(`RLDBG_ADDR_IRQ_MASK, 32'h4);
		rd_chk(`RLDBG_ADDR_IRQ_MASK, 32'hFFFF_FFFF, 32'h4);
		repeat (3) @(posedge clk);
		check(36'(irq), 36'h1);
		stat_drv <= {1'b1, 1'b1, 9'h0};
		repeat (6) @(posedge clk);
		axi_wr(`RLDBG_ADDR_IRQ_STATUS, 32'h1C);
		rd_chk(`RLDBG_ADDR_IRQ_STATUS, 32'h1C, 32'h0);
		check(36'(irq), 36'h0);
		stat_drv <= '0;
		repeat (6) @(posedge clk);
		rd_chk(`RLDBG_ADDR_IRQ_STATUS, 32'h23, 32'h23);
		axi_rd(`RLDBG_ADDR_LINK, d, r);
		check(36'({r, d[15:0] != 16'h0000}), 36'h1);
		complete_run();
	end
endmodule : test_radio_link_loopback_debug

`default_nettype wire
